//--- rtl/vhr_pkg.sv
// Purpose: Shared constants and types for the vertex header read-back block.
// Assumes: Classic Wishbone register access with 32-bit data and byte addresses.
// Notes:   Topology codes are local encodings of the incoming vertex context.
package vhr_pkg;

	// Header dword positions inside a vertex entry, dword zero first.
	localparam logic [2:0] VHR_DW_COARSE   = 3'h0;
	localparam logic [2:0] VHR_DW_LAYER    = 3'h1;
	localparam logic [2:0] VHR_DW_VIEWPORT = 3'h2;
	localparam logic [2:0] VHR_DW_PT_WIDTH = 3'h3;
	localparam logic [2:0] VHR_DW_POS_X    = 3'h4;
	localparam logic [2:0] VHR_DW_POS_Y    = 3'h5;

	// Coarse pixel size halves of dword zero.
	localparam int VHR_COARSE_Y_MSB = 31;
	localparam int VHR_COARSE_Y_LSB = 16;
	localparam int VHR_COARSE_X_MSB = 15;
	localparam int VHR_COARSE_X_LSB = 0;

	// Viewport parameter sets.
	localparam int VHR_NUM_VIEWPORTS = 16;
	localparam int VHR_VP_W          = $clog2(VHR_NUM_VIEWPORTS);

	// Topology codes carried with each vertex.
	localparam int         VHR_TOPO_W                        = 6;
	localparam logic [5:0] VHR_TOPO_POINT_LIST               = 6'h01;
	localparam logic [5:0] VHR_TOPO_POINT_LIST_BACKFACE      = 6'h02;

	// Register byte offsets.
	localparam logic [3:0] VHR_REG_CTRL        = 4'h0;
	localparam logic [3:0] VHR_REG_LAYER_RANGE = 4'h4;
	localparam logic [3:0] VHR_REG_STATUS      = 4'h8;
	localparam logic [3:0] VHR_REG_LAST_LAYER  = 4'hc;

	// Control register fields.
	localparam int VHR_CTRL_FORCE_ZERO_BIT = 0;
	localparam int VHR_CTRL_CLIP_EN_BIT    = 1;
	localparam int VHR_CTRL_COARSE_VTX_BIT = 2;
	localparam int VHR_CTRL_MAX_VP_LSB     = 4;
	localparam int VHR_CTRL_W              = 8;
	localparam logic [7:0] VHR_CTRL_RST    = 8'h02;

	// Layer range register fields.
	localparam int VHR_RANGE_FIRST_LSB       = 0;
	localparam int VHR_RANGE_LAST_LSB        = 16;
	localparam logic [31:0] VHR_RANGE_RST    = 32'h07ff_0000;

	// Status register fields.
	localparam int VHR_STAT_VP_ERR_BIT = 16;

	typedef enum logic [1:0] {
		VHR_ST_HEADER = 2'b01,
		VHR_ST_TAIL   = 2'b10
	} vhr_state_e;

endpackage : vhr_pkg

//--- rtl/vhr_vertex_header_readback.sv
// Purpose: Decodes the fixed header of each vertex entry and applies overrides.
// Assumes: Header dwords arrive from the return buffer on the pipeline clock.
// Notes:   Results are presented one cycle after dword five has arrived and held until the next vertex.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RL1] Dword zero: coarse height in upper half, coarse width in lower half, float16.
// [RL2] Coarse size is used only in per-vertex coarse mode, otherwise disregarded.
// [RL3] The last pre-raster shader writes coarse size whenever it is consumed.
// [RL4] Dword one is the 32-bit layer index, read back for every vertex.
// [RL5] The layer index is forwarded to pixel payload and render target write header.
// [RL6] The shader writes zero, or an index in 0 to 2047.
// [RL7] Force-zero selects layer 0, else the index is clamped into the surface range.
// [RL8] Dword two is the viewport index choosing one of 16 sets; the code uses set zero whenever clipping is disabled.
// [RL9] With clipping enabled, the viewport index is checked against 0 to maximum.
// [RL10] A maximum viewport select of zero makes every vertex use viewport zero.
// [RL11] Dword three is point width as float32, read back by the clip unit.
// [RL12] Point width applies only to point-list and back-facing point-list vertices.
// [RL13] Dword four is position X as float32.
// [RL14] Dword five is position Y as float32, all bits.
// [RL15] Every read-back entry starts with a valid header unless shaders consume it.
// [RL16] Header dwords are consecutive from the entry start, one word each.
module vhr_vertex_header_readback
	import vhr_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  sys_rst_in,
	// Wishbone classic slave.
	input  wire logic                  wb_cyc_in,
	input  wire logic                  wb_stb_in,
	input  wire logic                  wb_we_in,
	input  wire logic [3:0]            wb_adr_in,
	input  wire logic [3:0]            wb_sel_in,
	input  wire logic [31:0]           wb_dat_in,
	output logic      [31:0]           wb_dat_out,
	output logic                       wb_ack_out,
	// Vertex entry words from the return buffer.
	input  wire logic                  entry_word_valid_in,
	input  wire logic                  entry_word_first_in,
	input  wire logic [31:0]           entry_word_in,
	input  wire logic [VHR_TOPO_W-1:0] entry_topology_in,
	// Decoded header.
	output logic                       vtx_valid_out,
	output logic                       coarse_use_out,
	output logic      [15:0]           coarse_size_x_out,
	output logic      [15:0]           coarse_size_y_out,
	output logic      [31:0]           pixel_payload_layer_out,
	output logic      [31:0]           render_target_write_layer_out,
	output logic      [VHR_VP_W-1:0]   viewport_select_out,
	output logic                       point_width_use_out,
	output logic      [31:0]           point_width_out,
	output logic      [31:0]           position_x_out,
	output logic      [31:0]           position_y_out
);

	typedef struct packed {
		vhr_state_e             st;
		logic [2:0]             dw_idx;
		// Header words held until the entry's last header word arrives.
		logic [31:0]            hdr_coarse;
		logic [31:0]            hdr_layer;
		logic [31:0]            hdr_viewport;
		logic [31:0]            hdr_pt_width;
		logic [31:0]            hdr_pos_x;
		logic [VHR_TOPO_W-1:0]  topology;
		// Software-visible registers.
		logic [VHR_CTRL_W-1:0]  ctrl;
		logic [31:0]            layer_range;
		logic [15:0]            vtx_count;
		logic                   vp_err;
		// Registered outputs.
		logic [31:0]            wb_dat;
		logic                   wb_ack;
		logic                   vtx_valid;
		logic                   coarse_use;
		logic [15:0]            coarse_x;
		logic [15:0]            coarse_y;
		logic [31:0]            layer_payload;
		logic [31:0]            layer_rt_write;
		logic [VHR_VP_W-1:0]    viewport;
		logic                   pt_use;
		logic [31:0]            pt_width;
		logic [31:0]            pos_x;
		logic [31:0]            pos_y;
	} vhr_regs_s;

	localparam vhr_regs_s VHR_REGS_RST = '{
		st:             VHR_ST_HEADER,
		dw_idx:         3'h0,
		hdr_coarse:     32'h0000_0000,
		hdr_layer:      32'h0000_0000,
		hdr_viewport:   32'h0000_0000,
		hdr_pt_width:   32'h0000_0000,
		hdr_pos_x:      32'h0000_0000,
		topology:       '0,
		ctrl:           VHR_CTRL_RST,
		layer_range:    VHR_RANGE_RST,
		vtx_count:      16'h0000,
		vp_err:         1'b0,
		wb_dat:         32'h0000_0000,
		wb_ack:         1'b0,
		vtx_valid:      1'b0,
		coarse_use:     1'b0,
		coarse_x:       16'h0000,
		coarse_y:       16'h0000,
		layer_payload:  32'h0000_0000,
		layer_rt_write: 32'h0000_0000,
		viewport:       '0,
		pt_use:         1'b0,
		pt_width:       32'h0000_0000,
		pos_x:          32'h0000_0000,
		pos_y:          32'h0000_0000
	};

	// Current and next state of the whole block.
	vhr_regs_s r_r;
	vhr_regs_s r_nxt;

	// Merges write data into a stored word, one byte lane per select bit.
	function automatic logic [31:0] vhr_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction : vhr_merge

	logic                wb_req;
	logic                wb_wr;
	logic                force_zero;
	logic                clip_en;
	logic                coarse_vtx_mode;
	logic [VHR_VP_W-1:0] max_vp;
	logic [31:0]         first_layer_bound;
	logic [31:0]         last_layer_bound;
	logic [31:0]         layer_sel;
	logic [VHR_VP_W-1:0] vp_sel;
	logic                vp_bad;
	logic                hdr_done;
	logic [31:0]         ctrl_wide;
	logic [31:0]         ctrl_merged;
	logic                pt_topo;

	// A request is taken only while ack is low, so a strobe held past its ack is not taken twice.
	always_comb begin
		wb_req            = wb_cyc_in && wb_stb_in && !r_r.wb_ack;
		wb_wr             = wb_req && wb_we_in;
		force_zero        = r_r.ctrl[VHR_CTRL_FORCE_ZERO_BIT];
		clip_en           = r_r.ctrl[VHR_CTRL_CLIP_EN_BIT];
		coarse_vtx_mode   = r_r.ctrl[VHR_CTRL_COARSE_VTX_BIT];
		max_vp            = r_r.ctrl[VHR_CTRL_MAX_VP_LSB +: VHR_VP_W];
		first_layer_bound = {16'h0000, r_r.layer_range[VHR_RANGE_FIRST_LSB +: 16]};
		last_layer_bound  = {16'h0000, r_r.layer_range[VHR_RANGE_LAST_LSB +: 16]};
		ctrl_wide         = {{(32-VHR_CTRL_W){1'b0}}, r_r.ctrl};
		ctrl_merged       = vhr_merge(ctrl_wide, wb_dat_in, wb_sel_in);
		pt_topo           = (r_r.topology == VHR_TOPO_POINT_LIST)
			|| (r_r.topology == VHR_TOPO_POINT_LIST_BACKFACE); // RL12

		// Dword five completes the header of the current entry.
		hdr_done = entry_word_valid_in && (r_r.st == VHR_ST_HEADER) && !entry_word_first_in
			&& (r_r.dw_idx == VHR_DW_POS_Y); // RL16
	end

	// The layer is forced to zero, or else clamped into the surface layer range.
	always_comb begin
		if (force_zero) begin
			layer_sel = 32'h0000_0000; // RL7
		end else if (r_r.hdr_layer < first_layer_bound) begin
			layer_sel = first_layer_bound; // RL7
		end else if (r_r.hdr_layer > last_layer_bound) begin
			layer_sel = last_layer_bound; // RL7
		end else begin
			layer_sel = r_r.hdr_layer; // RL4
		end
	end

	// Out-of-range indices and a zero maximum both fall back to viewport set zero.
	always_comb begin
		vp_bad = clip_en && (r_r.hdr_viewport > {{(32-VHR_VP_W){1'b0}}, max_vp}); // RL9
		if (!clip_en || vp_bad || (max_vp == '0)) begin
			vp_sel = '0; // RL10
		end else begin
			vp_sel = r_r.hdr_viewport[VHR_VP_W-1:0]; // RL8
		end
	end

	always_comb begin
		r_nxt           = r_r;
		r_nxt.vtx_valid = 1'b0;
		r_nxt.wb_ack    = wb_req;

		// Header capture, one dword per valid word, starting at dword zero.
		if (entry_word_valid_in) begin
			// A first marker restarts the entry, even in the middle of a header.
			if (entry_word_first_in) begin
				r_nxt.hdr_coarse = entry_word_in; // RL1
				r_nxt.topology   = entry_topology_in;
				r_nxt.dw_idx     = VHR_DW_LAYER; // RL16
				r_nxt.st         = VHR_ST_HEADER;
			end else if (r_r.st == VHR_ST_HEADER) begin
				unique case (r_r.dw_idx)
					VHR_DW_LAYER: begin
						r_nxt.hdr_layer = entry_word_in; // RL4
					end
					VHR_DW_VIEWPORT: begin
						r_nxt.hdr_viewport = entry_word_in; // RL8
					end
					VHR_DW_PT_WIDTH: begin
						r_nxt.hdr_pt_width = entry_word_in; // RL11
					end
					VHR_DW_POS_X: begin
						r_nxt.hdr_pos_x = entry_word_in; // RL13
					end
					default: begin
						// Dword five and any slot past it close the header.
						r_nxt.st = VHR_ST_TAIL;
					end
				endcase
				r_nxt.dw_idx = r_r.dw_idx + 3'h1; // RL16
			end
		end

		// Words before the first marker of an entry are not a header.
		if (r_r.st == VHR_ST_HEADER && r_r.dw_idx == VHR_DW_COARSE && entry_word_valid_in
			&& !entry_word_first_in) begin
			r_nxt.st     = VHR_ST_TAIL;
			r_nxt.dw_idx = r_r.dw_idx;
		end

		// Results of a finished header use the register values in force at its last word.
		if (hdr_done) begin
			r_nxt.vtx_valid      = 1'b1;
			r_nxt.coarse_use     = coarse_vtx_mode; // RL2
			if (coarse_vtx_mode) begin
				r_nxt.coarse_y = r_r.hdr_coarse[VHR_COARSE_Y_MSB:VHR_COARSE_Y_LSB]; // RL1
				r_nxt.coarse_x = r_r.hdr_coarse[VHR_COARSE_X_MSB:VHR_COARSE_X_LSB]; // RL1
			end else begin
				r_nxt.coarse_y = 16'h0000; // RL2
				r_nxt.coarse_x = 16'h0000; // RL2
			end
			r_nxt.layer_payload  = layer_sel; // RL5
			r_nxt.layer_rt_write = layer_sel; // RL5
			r_nxt.viewport       = vp_sel; // RL9
			r_nxt.pt_use         = pt_topo; // RL12
			if (pt_topo) begin
				r_nxt.pt_width = r_r.hdr_pt_width; // RL11
			end else begin
				r_nxt.pt_width = 32'h0000_0000; // RL12
			end
			r_nxt.pos_x          = r_r.hdr_pos_x; // RL13
			r_nxt.pos_y          = entry_word_in; // RL14
			// The vertex count wraps at its width.
			r_nxt.vtx_count      = r_r.vtx_count + 16'h0001;
		end

		// Register writes.
		if (wb_wr) begin
			unique case (wb_adr_in)
				VHR_REG_CTRL: begin
					r_nxt.ctrl = ctrl_merged[VHR_CTRL_W-1:0];
				end
				VHR_REG_LAYER_RANGE: begin
					r_nxt.layer_range = vhr_merge(r_r.layer_range, wb_dat_in, wb_sel_in);
				end
				VHR_REG_STATUS: begin
					// Writing one to the error flag clears it; a set in the same cycle still wins below.
					if (wb_sel_in[VHR_STAT_VP_ERR_BIT/8] && wb_dat_in[VHR_STAT_VP_ERR_BIT]) begin
						r_nxt.vp_err = 1'b0;
					end
				end
				VHR_REG_LAST_LAYER: begin
					// This word only mirrors the applied layer; a write leaves it alone.
				end
				default: begin
				end
			endcase
		end

		// A range violation in the same cycle as a clear still sets the flag.
		if (hdr_done && vp_bad) begin
			r_nxt.vp_err = 1'b1; // RL9
		end

		// Register reads; unmapped offsets read as zero and are still acknowledged.
		r_nxt.wb_dat = 32'h0000_0000;
		if (wb_req && !wb_we_in) begin
			unique case (wb_adr_in)
				VHR_REG_CTRL: begin
					r_nxt.wb_dat = ctrl_wide;
				end
				VHR_REG_LAYER_RANGE: begin
					r_nxt.wb_dat = r_r.layer_range;
				end
				VHR_REG_STATUS: begin
					r_nxt.wb_dat = {15'h0000, r_r.vp_err, r_r.vtx_count};
				end
				VHR_REG_LAST_LAYER: begin
					r_nxt.wb_dat = r_r.layer_payload;
				end
				default: begin
					r_nxt.wb_dat = 32'h0000_0000;
				end
			endcase
		end
	end

	// All state resets together, and every output below reads these flops directly.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			r_r <= VHR_REGS_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Bus answer.
	assign wb_dat_out                    = r_r.wb_dat;
	assign wb_ack_out                    = r_r.wb_ack;

	// Decoded header of the most recent finished vertex.
	assign vtx_valid_out                 = r_r.vtx_valid;
	assign coarse_use_out                = r_r.coarse_use;
	assign coarse_size_x_out             = r_r.coarse_x;
	assign coarse_size_y_out             = r_r.coarse_y;
	assign pixel_payload_layer_out       = r_r.layer_payload;
	assign render_target_write_layer_out = r_r.layer_rt_write;
	assign viewport_select_out           = r_r.viewport;
	assign point_width_use_out           = r_r.pt_use;
	assign point_width_out               = r_r.pt_width;
	assign position_x_out                = r_r.pos_x;
	assign position_y_out                = r_r.pos_y;

endmodule : vhr_vertex_header_readback

`default_nettype wire

//--- tb/vhr_hdr_chk_sva.sv
// Purpose: Port-level checks for the vertex header read-back block.
// Assumes: One clock domain with an active high asynchronous reset.
// Notes:   Attached to every instance of the block by the bind below.
`timescale 1ns/100ps
`default_nettype none
module vhr_hdr_chk (
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_ack_out,
	input wire logic        entry_word_valid_in,
	input wire logic        vtx_valid_out,
	input wire logic        coarse_use_out,
	input wire logic [15:0] coarse_size_x_out,
	input wire logic [15:0] coarse_size_y_out,
	input wire logic [31:0] pixel_payload_layer_out,
	input wire logic [31:0] render_target_write_layer_out,
	input wire logic        point_width_use_out,
	input wire logic [31:0] point_width_out,
	input wire logic [31:0] position_x_out,
	input wire logic [31:0] position_y_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
		else $error("register access not answered by a single ack");
	a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without a request");
	a_vtx_pulse: assert property (vtx_valid_out |=> !vtx_valid_out [*5])
		else $error("vertex results closer than six words");
	a_vtx_cause: assert property (vtx_valid_out |-> $past(entry_word_valid_in))
		else $error("vertex results without a final word");
	a_layer_mirror: assert property (pixel_payload_layer_out == render_target_write_layer_out)
		else $error("payload and write layers differ");
	a_coarse_off: assert property (!coarse_use_out |-> coarse_size_x_out == 16'h0 && coarse_size_y_out == 16'h0)
		else $error("coarse size shown while unused");
	a_point_off: assert property (!point_width_use_out |-> point_width_out == 32'h0)
		else $error("point width shown for other topology");
	a_outs_hold: assert property (!vtx_valid_out |-> $stable(position_x_out) && $stable(position_y_out))
		else $error("position changed between vertices");
	c_coarse: cover property (vtx_valid_out && coarse_use_out);
	c_point: cover property (vtx_valid_out && point_width_use_out);
	c_ack: cover property (wb_ack_out);
endmodule : vhr_hdr_chk
bind vhr_vertex_header_readback vhr_hdr_chk vhr_hdr_chk_inst (.ref_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .entry_word_valid_in, .vtx_valid_out, .coarse_use_out, .coarse_size_x_out, .coarse_size_y_out,
	.pixel_payload_layer_out, .render_target_write_layer_out, .point_width_use_out, .point_width_out,
	.position_x_out, .position_y_out);
`default_nettype wire

//--- tb/vhr_entry_src.sv
// Purpose: Shader-side writer of vertex entries toward the block.
// Assumes: Words change only just after a rising clock edge.
// Notes:   Idle cycles show the inverse of the last word; the topology is inverted on every word after the first and after an entry.
`timescale 1ns/100ps
`default_nettype none
module vhr_entry_src (
	input  wire logic        clk_in,
	output logic             valid_out,
	output logic             first_out,
	output logic      [31:0] word_out,
	output logic      [5:0]  topo_out
);
	initial begin
		valid_out = 1'b0;
		first_out = 1'b0;
		word_out  = 32'h0;
		topo_out  = 6'h0;
	end
	// A count below six sends a cut header; a gap inserts idle cycles.
	task automatic send(input int n, input logic [5:0] topo, input logic [5:0][31:0] w, input int gap);
		for (int i = 0; i < n; i++) begin
			if (gap != 0) begin
				@(posedge clk_in);
				valid_out <= 1'b0;
				word_out  <= ~word_out;
			end
			@(posedge clk_in);
			valid_out <= 1'b1;
			first_out <= (i == 0);
			word_out  <= w[i];
			topo_out  <= (i == 0) ? topo : ~topo;
		end
		@(posedge clk_in);
		valid_out <= 1'b0;
		first_out <= 1'b0;
		word_out  <= ~word_out;
		topo_out  <= ~topo_out;
	endtask : send
endmodule : vhr_entry_src
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the vertex header read-back block.
// Assumes: Classic Wishbone with one ack cycle; results one cycle after dword five.
// Notes:   Stimulus comes from a shift-register generator with a fixed start.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
	import vhr_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out;
	logic [3:0]  wb_adr_in = 4'h0, wb_sel_in = 4'h0, vp;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q, rs = 32'h48f4, ew, pl, rl, pw, px, py;
	logic        ev, ef, vtx_valid_out, coarse_use_out, point_width_use_out;
	logic [5:0]  et;
	logic [15:0] cx, cy;
	int          err_count = 0, compares = 0, cycles = 0;
	always #10 ref_clk_in = ~ref_clk_in;
	vhr_vertex_header_readback vhr_vertex_header_readback_inst (.ref_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in,
		.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .entry_word_valid_in(ev),
		.entry_word_first_in(ef), .entry_word_in(ew), .entry_topology_in(et), .vtx_valid_out, .coarse_use_out,
		.coarse_size_x_out(cx), .coarse_size_y_out(cy), .pixel_payload_layer_out(pl),
		.render_target_write_layer_out(rl), .viewport_select_out(vp), .point_width_use_out,
		.point_width_out(pw), .position_x_out(px), .position_y_out(py));
	vhr_entry_src vhr_entry_src_inst (.clk_in(ref_clk_in), .valid_out(ev), .first_out(ef), .word_out(ew),
		.topo_out(et));
	function automatic logic [31:0] rnd();
		rs = {1'b0, rs[31:1]} ^ (rs[0] ? 32'h8020_0003 : 32'h0);
		return rs;
	endfunction : rnd
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge ref_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		wb_sel_in <= s;
		do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb
	task automatic reset_regs_check();
		wb(1'b0, VHR_REG_CTRL, 32'h0, 4'hf);
		`CHK(q, 32'h0000_0002)
		wb(1'b0, VHR_REG_LAYER_RANGE, 32'h0, 4'hf);
		`CHK(q, VHR_RANGE_RST)
		wb(1'b0, VHR_REG_STATUS, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		wb(1'b0, 4'h2, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		wb(1'b1, VHR_REG_LAST_LAYER, 32'hff, 4'hf);
		wb(1'b0, VHR_REG_LAST_LAYER, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		`CHK({coarse_use_out, point_width_use_out, cx, cy, vp, pl, rl, pw, px, py}, 198'h0)
	endtask : reset_regs_check
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		logic [5:0][31:0] w;
		logic [31:0]      ctrl, rng, xl, xv;
		logic [5:0]       tp;
		int               n;
		logic             vpe;
		vpe = 1'b0;
		repeat (16) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		reset_regs_check();
		wb(1'b1, VHR_REG_LAYER_RANGE, 32'hffff_0005, 4'h3);
		wb(1'b0, VHR_REG_LAYER_RANGE, 32'h0, 4'hf);
		`CHK(q, 32'h07ff_0005)
		$display("register reset test done");
		for (int i = 0; i < 48; i++) begin
			ctrl = rnd() & 32'hf7;
			rng = rnd() & 32'h07ff_07ff;
			for (int k = 0; k < 6; k++)
				w[k] = rnd();
			w[1] = w[1] & 32'h7ff;
			w[2] = w[2] & 32'h1f;
			tp = (i % 3 == 0) ? VHR_TOPO_POINT_LIST : (i % 3 == 1) ? VHR_TOPO_POINT_LIST_BACKFACE : rs[5:0] & 6'h3c;
			wb(1'b1, VHR_REG_CTRL, ctrl, 4'hf);
			wb(1'b1, VHR_REG_LAYER_RANGE, rng, 4'hf);
			vpe = vpe | (ctrl[1] && (w[2] > {28'h000_0000, ctrl[7:4]}));
			if (i % 4 == 0)
				vhr_entry_src_inst.send(3, tp, ~w, 0);
			vhr_entry_src_inst.send(6, tp, w, i % 2);
			n = 0;
			do begin
				@(negedge ref_clk_in);
				n++;
			end while (vtx_valid_out !== 1'b1 && n < 20);
			xl = ctrl[0] ? 32'h0 : (w[1] < rng[15:0]) ? rng[15:0] : (w[1] > rng[31:16]) ? rng[31:16] : w[1];
			xv = (!ctrl[1] || ctrl[7:4] == 4'h0 || w[2] > ctrl[7:4]) ? 32'h0 : w[2];
			`CHK(vtx_valid_out, 1'b1)
			`CHK(coarse_use_out, ctrl[2])
			`CHK({cy, cx}, ctrl[2] ? w[0] : 32'h0)
			`CHK(pl, xl)
			`CHK(rl, xl)
			`CHK(vp, xv[3:0])
			`CHK(point_width_use_out, tp == 6'h01 || tp == 6'h02)
			`CHK(pw, (tp == 6'h01 || tp == 6'h02) ? w[3] : 32'h0)
			`CHK(px, w[4])
			`CHK(py, w[5])
			wb(1'b0, VHR_REG_LAST_LAYER, 32'h0, 4'hf);
			`CHK(q, xl)
		end
		$display("vertex decode test done");
		wb(1'b0, VHR_REG_STATUS, 32'h0, 4'hf);
		`CHK(q, {15'h0000, vpe, 16'h0030})
		wb(1'b1, VHR_REG_STATUS, 32'h0001_0000, 4'h4);
		wb(1'b0, VHR_REG_STATUS, 32'h0, 4'hf);
		`CHK(q, 32'h0000_0030)
		$display("status test done");
		@(posedge ref_clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		reset_regs_check();
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
